// >>> pkg/dac_ctrl_pkg.sv
// Purpose: Shared constants and types for the stereo converter digital control.
// Assumes: One 40 MHz system clock; all converter pins are sampled into it.
// Notes: Control words are 16 bits; register selector sits in bits 15..14.
`default_nettype none
package dac_ctrl_pkg;
	// Control word layout
	localparam int CTL_WIDTH = 16;
	localparam int SEL_HI = 15;
	localparam int SEL_LO = 14;
	localparam logic [1:0] SEL_LEVEL = 2'h0;
	localparam logic [1:0] SEL_SYSTEM = 2'h1;
	// Output level control fields
	localparam int LVL_DEEMPH_BIT = 13;
	localparam int LVL_MUTE_BIT = 12;
	localparam int LVL_GAIN_HI = 10;
	localparam logic [10:0] GAIN_UNITY = 11'h400;
	// System configuration fields
	localparam int SYS_LSB_FIRST_BIT = 13;
	localparam int SYS_WORD18_BIT = 12;
	localparam int SYS_LONG_ZERO_BIT = 5;
	localparam int SYS_DEEMPH_HI = 3;
	localparam int SYS_DEEMPH_LO = 2;
	localparam int SYS_SYNC_BIT = 1;
	// Reset values
	localparam logic [15:0] LEVEL_RESET = 16'h0400;
	localparam logic [15:0] SYSTEM_RESET = 16'h0000;
	// Timing counts in sample periods and master clocks
	localparam int MASTER_PER_SAMPLE = 512;
	localparam int MASTER_PER_MOD = 16;
	localparam int OVERSAMPLE = 32;
	localparam int RESET_ENTRY_SAMPLES = 120;
	localparam int RESET_EXIT_FRAMES = 5;
	localparam int ZERO_SHORT = 2500;
	localparam int ZERO_LONG = 12500;
	localparam int AUDIO_W = 18;
	// Decoded configuration carried to the datapath
	typedef struct packed {
		logic deemph_on;
		logic chan_mute;
		logic [10:0] gain;
		logic lsb_first;
		logic word18;
		logic long_zero;
		logic [1:0] deemph_rate;
		logic mod_sync;
	} config_s;
	// Per-channel stream output
	typedef struct packed {
		logic [AUDIO_W-1:0] left;
		logic [AUDIO_W-1:0] right;
	} stereo_s;
endpackage
`default_nettype wire

// >>> hdl/dac_digital_control.sv
// Purpose: Digital front end of a stereo oversampling converter.
// Assumes: Pins are asynchronous and pass two flops; master clock sampled too.
// Notes: Modulator and filters are outside; this block supplies attenuated
// samples, mute state, timing strobes and configuration.
`timescale 1ns/10ps
`default_nettype none
module dac_digital_control
	import dac_ctrl_pkg::*;
(
	// System
	input wire logic clock,
	input wire logic rstn,
	// Converter pins
	input wire logic init_n,
	input wire logic master_clock_in,
	input wire logic channel_select_clock,
	input wire logic audio_bit_clock,
	input wire logic audio_data,
	input wire logic control_serial_in,
	input wire logic control_shift_clock,
	input wire logic control_load_n,
	// Flags and clocks out
	output logic left_silence_flag_n,
	output logic right_silence_flag_n,
	output logic half_master_clock_out,
	// Datapath toward the modulator
	output dac_ctrl_pkg::stereo_s sample_out,
	output logic sample_valid,
	output logic mod_tick,
	output logic frame_start,
	output logic internal_reset,
	output dac_ctrl_pkg::config_s cfg
);
	import dac_ctrl_pkg::*;

	// Two-flop synchronisers for every pin
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic [7:0] pin_last;
	wire [7:0] pin_raw = {init_n, master_clock_in, channel_select_clock, audio_bit_clock,
		audio_data, control_serial_in, control_shift_clock, control_load_n};

	// First stage feeds only the second
	// Reset to the idle pin levels so no false strobe or shift edge follows reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin_meta <= 8'h83;
			pin_sync <= 8'h83;
			pin_last <= 8'h83;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	// Named views of the synchronised pins
	wire init_s = pin_sync[7];
	wire channel_select_clock_s = pin_sync[5];
	wire din_s = pin_sync[3];
	wire ctl_in_s = pin_sync[2];
	wire shift_rise = pin_sync[1] & ~pin_last[1];
	wire load_fall = ~pin_sync[0] & pin_last[0];
	wire xin_rise = pin_sync[6] & ~pin_last[6];
	wire bck_rise = pin_sync[4] & ~pin_last[4];
	wire channel_select_clock_rise = channel_select_clock_s & ~pin_last[5];
	wire channel_select_clock_edge = channel_select_clock_s ^ pin_last[5];

	// Master clock divided by two drives the system clock output
	logic half_div;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) half_div <= 1'b0;
		else if (xin_rise) half_div <= ~half_div;
	end
	assign half_master_clock_out = half_div;

	// Master-clock phase within a sample; rise of channel clock realigns it while sync is set or internal reset is active
	logic [8:0] phase;
	wire realign = channel_select_clock_rise & (cfg.mod_sync | internal_reset);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) phase <= 9'h000;
		else if (realign) phase <= 9'h000;
		else if (xin_rise) phase <= phase + 9'h001;
	end
	// One modulator value per 16 masters, 32 per sample
	assign mod_tick = xin_rise & (phase[3:0] == 4'(MASTER_PER_MOD - 1));
	assign frame_start = channel_select_clock_rise;

	// Internal reset sequencing, counted in sample periods
	logic [6:0] entry_cnt;
	logic [2:0] exit_cnt;
	wire sample_tick = xin_rise & (phase == 9'(MASTER_PER_SAMPLE - 1));
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			entry_cnt <= 7'h00;
			exit_cnt <= 3'h0;
			internal_reset <= 1'b1;
		end else if (!init_s) begin
			exit_cnt <= 3'h0;
			// Entry delay measured on the master-derived sample rate
			if (sample_tick && entry_cnt != 7'(RESET_ENTRY_SAMPLES))
				entry_cnt <= entry_cnt + 7'h01;
			if (entry_cnt == 7'(RESET_ENTRY_SAMPLES)) internal_reset <= 1'b1;
		end else begin
			entry_cnt <= 7'h00;
			// Release after frames of the channel clock, which must keep running
			if (internal_reset && channel_select_clock_rise) begin
				if (exit_cnt == 3'(RESET_EXIT_FRAMES - 1)) internal_reset <= 1'b0;
				else exit_cnt <= exit_cnt + 3'h1;
			end
		end
	end

	// Control shift register, least significant bit first
	logic [15:0] ctl_shift;
	logic [15:0] level_reg;
	logic [15:0] system_reg;
	wire [1:0] ctl_sel = ctl_shift[SEL_HI:SEL_LO];
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) ctl_shift <= 16'h0000;
		else if (shift_rise) ctl_shift <= {ctl_in_s, ctl_shift[15:1]};
	end

	// Registers load on strobe fall; invalid selector leaves both untouched
	// Reserved bits are stored as written; the host keeps them zero
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			level_reg <= LEVEL_RESET;
			system_reg <= SYSTEM_RESET;
		end else if (load_fall) begin
			if (ctl_sel == SEL_LEVEL) level_reg <= ctl_shift;
			else if (ctl_sel == SEL_SYSTEM) system_reg <= ctl_shift;
		end
	end

	// Field decode for the datapath
	assign cfg.deemph_on = level_reg[LVL_DEEMPH_BIT];
	assign cfg.chan_mute = level_reg[LVL_MUTE_BIT];
	assign cfg.gain = level_reg[LVL_GAIN_HI:0];
	assign cfg.lsb_first = system_reg[SYS_LSB_FIRST_BIT];
	assign cfg.word18 = system_reg[SYS_WORD18_BIT];
	assign cfg.long_zero = system_reg[SYS_LONG_ZERO_BIT];
	// Coefficient set is honoured by the filter only at the tabled rates
	assign cfg.deemph_rate = system_reg[SYS_DEEMPH_HI:SYS_DEEMPH_LO];
	assign cfg.mod_sync = system_reg[SYS_SYNC_BIT];

	// Audio word capture; word ends when the channel clock toggles
	logic [17:0] aud_shift;
	logic [4:0] bit_cnt;
	logic word_left;
	wire [4:0] word_len = cfg.word18 ? 5'd18 : 5'd16;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			aud_shift <= 18'h00000;
			bit_cnt <= 5'h00;
			word_left <= 1'b0;
		end else if (channel_select_clock_edge) begin
			bit_cnt <= 5'h00;
			word_left <= channel_select_clock_s;
		end else if (bck_rise && bit_cnt != word_len) begin
			bit_cnt <= bit_cnt + 5'h01;
			if (cfg.lsb_first) aud_shift <= {din_s, aud_shift[17:1]};
			else aud_shift <= {aud_shift[16:0], din_s};
		end
	end

	// Right-justify an LSB-first word and sign-extend 16-bit words
	wire [17:0] lsb_aligned = cfg.word18 ? aud_shift : {2'h0, aud_shift[17:2]};
	wire [17:0] raw_word = cfg.lsb_first ? lsb_aligned : aud_shift;
	wire signed [17:0] word_val = cfg.word18 ? raw_word :
		{{2{raw_word[15]}}, raw_word[15:0]};
	wire word_zero = (word_val == 18'sh00000);

	// Gain: value * code / 1024, a linear stand-in for the curve
	wire signed [29:0] scaled = word_val * $signed({1'b0, cfg.gain});
	wire signed [17:0] atten_val = scaled[27:10];

	// Zero-run counters per channel
	logic [13:0] zero_cnt [2];
	logic [1:0] silent;
	wire [13:0] zero_limit = cfg.long_zero ? 14'(ZERO_LONG) : 14'(ZERO_SHORT);
	for (genvar ch = 0; ch < 2; ch++) begin : g_zero
		wire mine = (ch == 0) ? word_left : ~word_left;
		wire take = channel_select_clock_edge & mine;
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				zero_cnt[ch] <= 14'h0000;
				silent[ch] <= 1'b0;
			end else if (internal_reset) begin
				zero_cnt[ch] <= 14'h0000;
				silent[ch] <= 1'b0;
			end else if (take) begin
				if (!word_zero) begin
					zero_cnt[ch] <= 14'h0000;
					silent[ch] <= 1'b0;
				end else if (zero_cnt[ch] + 14'h0001 >= zero_limit) begin
					silent[ch] <= 1'b1;
				end else begin
					zero_cnt[ch] <= zero_cnt[ch] + 14'h0001;
				end
			end
		end
	end

	// Mute on zero run, control bit or reset; the flag shows mute too
	wire mute_l = silent[0] | cfg.chan_mute | internal_reset;
	wire mute_r = silent[1] | cfg.chan_mute | internal_reset;
	assign left_silence_flag_n = ~mute_l;
	assign right_silence_flag_n = ~mute_r;

	// Sample hold; muted channels carry zero data, that is mid-scale duty
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sample_out <= '0;
			sample_valid <= 1'b0;
		end else begin
			sample_valid <= channel_select_clock_edge & ~internal_reset;
			if (mute_l) sample_out.left <= '0;
			else if (channel_select_clock_edge && word_left) sample_out.left <= atten_val;
			if (mute_r) sample_out.right <= '0;
			else if (channel_select_clock_edge && !word_left) sample_out.right <= atten_val;
		end
	end
endmodule
`default_nettype wire

// >>> dv/dac_ctrl_checker.sv
// Purpose: Concurrent checks on the converter control ports.
// Assumes: Master clock pin at a quarter of the system clock rate.
// Notes: Bound to every instance of the top module; reset pin held high by the bench.
`timescale 1ns/10ps
`default_nettype none
module dac_ctrl_checker (
	// System and pins
	input wire logic clock, rstn, init_n, master_clock_in, channel_select_clock,
	input wire logic audio_bit_clock, audio_data, control_serial_in,
	input wire logic control_shift_clock, control_load_n,
	// Outputs watched
	input wire logic left_silence_flag_n, right_silence_flag_n, half_master_clock_out,
	input wire dac_ctrl_pkg::stereo_s sample_out,
	input wire logic sample_valid, mod_tick, frame_start, internal_reset,
	input wire dac_ctrl_pkg::config_s cfg
);
	import dac_ctrl_pkg::*;
	// One domain, so clock and reset are given once
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	AST_RESET_QUIET: assert property (internal_reset |->
		!left_silence_flag_n && !right_silence_flag_n && sample_out == '0)
		else $error("flags or samples live during reset");
	AST_MUTE_FLAGS: assert property (cfg.chan_mute |->
		##[0:2] !left_silence_flag_n && !right_silence_flag_n) else $error("mute bit ignored");
	AST_MUTE_ZERO: assert property (sample_valid && cfg.chan_mute && $past(cfg.chan_mute, 3) |->
		sample_out == '0) else $error("muted channel not zero");
	AST_HALF_RATE: assert property ($changed(half_master_clock_out) |=>
		$stable(half_master_clock_out) [*3]) else $error("half clock too fast");
	AST_FRAME_RISE: assert property (frame_start |-> channel_select_clock ##1 !frame_start)
		else $error("frame start off channel rise");
	AST_MOD_SPACING: assert property (mod_tick |=> !mod_tick [*8])
		else $error("modulation ticks too close");
	AST_LOAD_EDGE: assert property ($changed(cfg) && !internal_reset |->
		!$past(control_load_n, 3)) else $error("config changed without strobe");
	AST_RELEASE_ALIGN: assert property ($fell(internal_reset) |-> channel_select_clock)
		else $error("reset release not aligned");
	AST_FLAG_BACK: assert property (sample_valid && sample_out.left != '0 && !cfg.chan_mute
		&& !internal_reset |-> ##[0:2] left_silence_flag_n)
		else $error("left flag stays low on data");
	// Main scenarios reached
	cover property ($fell(internal_reset));
	cover property (sample_valid && cfg.chan_mute);
	cover property (frame_start && left_silence_flag_n);
endmodule
bind dac_digital_control dac_ctrl_checker chk (.clock(clock), .rstn(rstn), .init_n(init_n),
	.master_clock_in(master_clock_in), .channel_select_clock(channel_select_clock),
	.audio_bit_clock(audio_bit_clock), .audio_data(audio_data), .cfg(cfg),
	.control_serial_in(control_serial_in), .control_shift_clock(control_shift_clock),
	.control_load_n(control_load_n), .left_silence_flag_n(left_silence_flag_n),
	.right_silence_flag_n(right_silence_flag_n), .sample_out(sample_out),
	.half_master_clock_out(half_master_clock_out), .sample_valid(sample_valid),
	.mod_tick(mod_tick), .frame_start(frame_start), .internal_reset(internal_reset));
`default_nettype wire

// >>> dv/audio_source_model.sv
// Purpose: Audio source driving master clock, channel clock and serial words.
// Assumes: Words are 16 bits, most significant first, the reset format.
// Notes: Clocks run free so initialisation can always finish.
`timescale 1ns/10ps
`default_nettype none
module audio_source_model (
	// Clock
	input wire logic clock,
	// Words to send
	input wire logic [15:0] left_word, right_word,
	// Pins toward the converter
	output logic master_clock_in, channel_select_clock, audio_bit_clock, audio_data
);
	logic [1:0] mdiv = 2'h0; // Master divider, 10 MHz keeps it visible
	logic [2:0] phase = 3'h0; // Position inside one bit period of six clocks
	logic [3:0] bitn = 4'h0; // Bit index within the half frame
	wire logic [3:0] next_bit = bitn + 4'h1;
	wire logic next_chan = channel_select_clock ^ (bitn == 4'hf);
	wire logic [15:0] next_word = next_chan ? left_word : right_word;
	initial {master_clock_in, channel_select_clock, audio_bit_clock, audio_data} = 4'h0;
	// Never stops, also during reset; 32 bit clocks per frame
	always @(posedge clock) begin
		mdiv <= mdiv + 2'h1;
		master_clock_in <= mdiv[1];
		phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
		audio_bit_clock <= (phase >= 3'h2) && (phase != 3'h5);
		if (phase == 3'h5) begin
			// Data and channel change while the bit clock is low
			bitn <= next_bit;
			channel_select_clock <= next_chan;
			audio_data <= next_word[4'hf - next_bit];
		end
	end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the converter digital control.
// Assumes: Control words go out through the three-wire port only.
// Notes: Zero-run timing is too long to reach; assertions watch the rest.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import dac_ctrl_pkg::*;
	logic clock = 1'b0, rstn = 1'b0, init_n = 1'b1;
	logic control_serial_in = 1'b0, control_shift_clock = 1'b1, control_load_n = 1'b1;
	logic [15:0] left_word = 16'h1234, right_word = 16'h8001; // Nonzero audio
	wire logic master_clock_in, channel_select_clock, audio_bit_clock, audio_data;
	wire logic left_silence_flag_n, right_silence_flag_n, half_master_clock_out;
	wire logic sample_valid, mod_tick, frame_start, internal_reset;
	stereo_s sample_out;
	config_s cfg;
	int mismatches = 0, comparisons = 0, n;
	always #12.5 clock = ~clock;
	audio_source_model src (.clock(clock), .left_word(left_word), .right_word(right_word),
		.master_clock_in(master_clock_in), .channel_select_clock(channel_select_clock),
		.audio_bit_clock(audio_bit_clock), .audio_data(audio_data));
	dac_digital_control uut (.clock(clock), .rstn(rstn), .init_n(init_n),
		.master_clock_in(master_clock_in), .channel_select_clock(channel_select_clock),
		.audio_bit_clock(audio_bit_clock), .audio_data(audio_data), .cfg(cfg),
		.control_serial_in(control_serial_in), .control_shift_clock(control_shift_clock),
		.control_load_n(control_load_n), .left_silence_flag_n(left_silence_flag_n),
		.right_silence_flag_n(right_silence_flag_n), .sample_out(sample_out),
		.half_master_clock_out(half_master_clock_out), .sample_valid(sample_valid),
		.mod_tick(mod_tick), .frame_start(frame_start), .internal_reset(internal_reset));
	task automatic check(input logic [35:0] seen, input logic [35:0] expected);
		comparisons++;
		if (seen !== expected) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// A bound that runs out is counted and ends the run
	task automatic guard(input logic ok);
		check(36'(ok), 36'h1);
		if (!ok) conclude();
	endtask
	// Rising edges, then settle to the falling edge before looking
	task automatic look(input int cycles);
		repeat (cycles) @(posedge clock);
		@(negedge clock);
	endtask
	// Least significant bit first, shift clock high well before the strobe
	task automatic write_ctl(input logic [15:0] w);
		@(posedge clock);
		for (int i = 0; i < 16; i++) begin
			control_serial_in <= w[i];
			control_shift_clock <= 1'b0;
			repeat (4) @(posedge clock);
			control_shift_clock <= 1'b1;
			repeat (4) @(posedge clock);
		end
		control_load_n <= 1'b0;
		repeat (6) @(posedge clock);
		control_load_n <= 1'b1;
		look(4);
	endtask
	initial begin
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		look(3);
		check(36'(cfg), 36'({2'h0, 11'h400, 6'h00}));
		check(36'({left_silence_flag_n, right_silence_flag_n, internal_reset}), 36'h1);
		// Five channel frames of 192 clocks plus synchronisers
		for (n = 0; n < 2000 && internal_reset !== 1'b0; n++) look(0);
		guard(n < 2000);
		look(400);
		check(36'({left_silence_flag_n, right_silence_flag_n}), 36'h3);
		// Unity gain passes both words, the right one sign-extended
		check(36'(sample_out), {18'h01234, 18'h38001});
		write_ctl(16'h3123);
		check(36'(cfg), 36'({2'h3, 11'h123, 6'h00}));
		look(200);
		check(36'({left_silence_flag_n, right_silence_flag_n}), 36'h0);
		for (n = 0; n < 300 && sample_valid !== 1'b1; n++) look(0);
		guard(n < 300);
		check(36'(sample_out), 36'h0);
		// Selector 1x must leave both registers alone
		write_ctl(16'hbfff);
		check(36'(cfg), 36'({2'h3, 11'h123, 6'h00}));
		write_ctl(16'hc000);
		check(36'(cfg), 36'({2'h3, 11'h123, 6'h00}));
		// Every de-emphasis rate with order, length, period and sync set
		// Reserved system bits stay zero in every word sent here
		for (int r = 0; r < 4; r++) begin
			write_ctl(16'h7022 | 16'(r << 2));
			check(36'(cfg), 36'({2'h3, 11'h123, 3'h7, 2'(r), 1'b1}));
		end
		conclude();
	end
endmodule
`default_nettype wire
